// file: verilog/bif_regs.svh
/*
 Bus interface control constants: cycle division, dummy and vector
 addresses, stretch, grant and reset limits.
 Assumes one system clock that stands for the crystal timing input.
*/
`ifndef BIF_REGS_SVH
`define BIF_REGS_SVH

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define BIF_QUARTERS 4
`define BIF_STRETCH_MAX_CYC 10
`define BIF_STRETCH_MAX_Q 6'd40
`define BIF_GRANT_MAX 4'd15
`define BIF_RST_MIN_Q 3'd5

// ---------------------------------------------------------------
// Addresses
// ---------------------------------------------------------------
`define BIF_DUMMY_ADDR 16'hffff
`define BIF_RST_VEC_HI 16'hfffe
`define BIF_RST_VEC_LO 16'hffff

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BIF_SYNC_RST 15'h7fff
`define BIF_PH_RST 2'h3

`endif

// file: verilog/bif_pkg.sv
/*
 Types shared by the bus interface controller.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bif_pkg;
   typedef logic [15:0] bif_addr_t;
   typedef logic [7:0] bif_data_t;
   typedef enum {ST_RESET_VEC, ST_RUN, ST_GRANT_DEAD, ST_GRANT, ST_RELEASE_DEAD, ST_REFRESH, ST_HALT} bif_state_t;
endpackage

// file: verilog/bif_bus_ctrl.sv
/*
 External bus interface and processor-state control of an 8-bit core:
 enable/quadrature clock generation, address/data timing, dummy cycles,
 state code outputs, reset vector fetch, interrupt latching, slow memory
 stretch, halt and bus grant with dead cycles and self-refresh.
 Assumes sys_clk_i is the timing input; the execution core sits on the
 core_* ports on the same clock; pins pass two flip-flops.
*/
`timescale 1ns/1ps
`include "bif_regs.svh"

module bif_bus_ctrl (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic reset_pin_n_i,
   input wire logic halt_n_i,
   input wire logic bus_request_in_n_i,
   input wire logic slow_memory_stretch_i,
   input wire logic nmi_n_i,
   input wire logic quick_int_req_n_i,
   input wire logic irq_n_i,
   input wire bif_pkg::bif_data_t data_i,
   output logic e_o,
   output logic q_o,
   output bif_pkg::bif_addr_t addr_o,
   output logic addr_oe_o,
   output bif_pkg::bif_data_t data_o,
   output logic data_oe_o,
   output logic rw_o,
   output logic rw_oe_o,
   output logic bus_avail_o,
   output logic proc_state_code_o,
   output logic final_cycle_marker_o,
   output logic busy_o,
   output logic next_cycle_use_o,
   input wire logic core_req_i,
   input wire bif_pkg::bif_addr_t core_addr_i,
   input wire logic core_wr_i,
   input wire bif_pkg::bif_data_t core_wdata_i,
   input wire logic core_last_i,
   input wire logic core_lock_i,
   input wire logic core_vector_i,
   input wire logic core_sync_i,
   input wire logic core_sp_loaded_i,
   input wire logic core_nmi_ack_i,
   input wire logic core_fmask_i,
   input wire logic core_imask_i,
   output logic core_step_o,
   output bif_pkg::bif_data_t core_rdata_o,
   output logic core_reset_o,
   output logic int_nmi_o,
   output logic int_quick_int_req_o,
   output logic int_irq_o
);
   import bif_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [14:0] sync1, sync2;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1 <= `BIF_SYNC_RST;
         sync2 <= `BIF_SYNC_RST;
      end else begin
         sync1 <= {reset_pin_n_i, halt_n_i, bus_request_in_n_i, slow_memory_stretch_i,
                   nmi_n_i, quick_int_req_n_i, irq_n_i, data_i};
         sync2 <= sync1;
      end
   end
   logic rst_s, halt_s, breq_s, rdy_s, nmi_s, quick_int_req_s, irq_s;
   bif_data_t data_s;
   assign {rst_s, halt_s, breq_s, rdy_s, nmi_s, quick_int_req_s, irq_s, data_s} = sync2;

   // ---------------------------------------------------------------
   // Quarter phase divider and stretch
   // ---------------------------------------------------------------
   logic [1:0] ph, next_ph;
   logic [5:0] stretch_q;
   logic cur_acc, cur_wr, hold, cyc_end, q_fall, e_fall;
   bif_data_t cur_wdata;
   assign hold = (ph == 2'h2) && cur_acc && !rdy_s && (stretch_q < `BIF_STRETCH_MAX_Q);
   assign next_ph = hold ? ph : ph + 2'h1;
   assign cyc_end = (ph == 2'h3);
   assign q_fall = (ph == 2'h1);
   // Edge on which enable drops, stretch included
   assign e_fall = (ph == 2'h2) && !hold;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ph <= `BIF_PH_RST;
         q_o <= 1'b0;
         e_o <= 1'b0;
         stretch_q <= 6'h0;
      end else begin
         ph <= next_ph;
         q_o <= (next_ph == 2'h0) || (next_ph == 2'h1);
         e_o <= (next_ph == 2'h1) || (next_ph == 2'h2);
         stretch_q <= cyc_end ? 6'h0 : stretch_q + {5'h0, hold};
      end
   end

   // ---------------------------------------------------------------
   // Reset pin qualification
   // ---------------------------------------------------------------
   logic [2:0] rst_cnt;
   logic int_rst;
   assign int_rst = (rst_cnt == `BIF_RST_MIN_Q);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_cnt <= 3'h0;
      end else if (rst_s) begin
         rst_cnt <= 3'h0;
      end else if (!int_rst) begin
         rst_cnt <= rst_cnt + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // Processor state sequencing
   // ---------------------------------------------------------------
   bif_state_t st, next_st;
   logic [3:0] gcnt;
   logic vec_idx, refresh_due, breq_seen, gnt_done, cur_sync, vec_lo;
   assign gnt_done = breq_s || (gcnt == `BIF_GRANT_MAX - 4'h1);
   // Low vector byte follows a high byte fetch already on the bus
   assign vec_lo = (st == ST_RESET_VEC) && !int_rst && cur_acc;

   always_comb begin
      next_st = st;
      if (int_rst) begin
         next_st = ST_RESET_VEC;
      end else begin
         case (st)
            ST_RESET_VEC: if (vec_idx) next_st = ST_RUN;
            ST_RUN: begin
               if (breq_seen) next_st = ST_GRANT_DEAD;
               else if (!halt_s && final_cycle_marker_o) next_st = ST_HALT;
            end
            ST_GRANT_DEAD: next_st = ST_GRANT;
            ST_GRANT: if (gnt_done) next_st = ST_RELEASE_DEAD;
            ST_HALT: begin
               if (breq_seen) next_st = ST_GRANT_DEAD;
               else if (halt_s) next_st = ST_RELEASE_DEAD;
            end
            ST_RELEASE_DEAD: next_st = refresh_due ? ST_REFRESH : ST_RUN;
            default: next_st = ST_RUN;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= ST_RESET_VEC;
         vec_idx <= 1'b0;
         gcnt <= 4'h0;
         refresh_due <= 1'b0;
      end else if (cyc_end) begin
         st <= next_st;
         vec_idx <= vec_lo && !vec_idx;
         gcnt <= (next_st == ST_GRANT) ? gcnt + 4'h1 : 4'h0;
         if (st == ST_GRANT && gnt_done) refresh_due <= !breq_s;
         else if (st == ST_REFRESH) refresh_due <= 1'b0;
      end
   end

   // Bus request only counts when seen during quadrature high
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         breq_seen <= 1'b0;
      end else if (cyc_end) begin
         breq_seen <= 1'b0;
      end else if (q_o && !breq_s) begin
         breq_seen <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Next bus cycle set-up
   // ---------------------------------------------------------------
   logic next_acc, next_wr, next_ba, next_bs, next_sync;
   bif_addr_t next_addr;
   always_comb begin
      next_acc = 1'b0;
      next_wr = 1'b0;
      next_ba = 1'b1;
      next_bs = 1'b1;
      next_sync = 1'b0;
      next_addr = `BIF_DUMMY_ADDR;
      case (next_st)
         ST_RESET_VEC: begin
            next_acc = !int_rst;
            next_ba = 1'b0;
            next_addr = int_rst ? `BIF_DUMMY_ADDR : (vec_lo ? `BIF_RST_VEC_LO : `BIF_RST_VEC_HI);
         end
         ST_RUN: begin
            next_sync = core_sync_i;
            next_bs = 1'b0;
            if (!core_sync_i) begin
               next_ba = 1'b0;
               next_acc = core_req_i;
               next_wr = core_req_i && core_wr_i;
               next_bs = core_req_i && core_vector_i;
               if (core_req_i) next_addr = core_addr_i;
            end
         end
         ST_RELEASE_DEAD, ST_REFRESH: begin
            next_ba = 1'b0;
            next_bs = 1'b0;
         end
         default: next_ba = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cur_acc <= 1'b0;
         cur_wr <= 1'b0;
         cur_sync <= 1'b0;
         cur_wdata <= 8'h0;
         addr_o <= `BIF_DUMMY_ADDR;
         addr_oe_o <= 1'b0;
         data_o <= 8'h0;
         data_oe_o <= 1'b0;
         rw_o <= 1'b1;
         rw_oe_o <= 1'b0;
         bus_avail_o <= 1'b0;
         proc_state_code_o <= 1'b1;
         final_cycle_marker_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (cyc_end) begin
         cur_acc <= next_acc;
         cur_wr <= next_wr;
         cur_sync <= next_sync;
         cur_wdata <= core_wdata_i;
         addr_o <= next_addr;
         addr_oe_o <= !next_ba && !bus_avail_o;
         data_o <= core_wdata_i;
         data_oe_o <= next_wr && !next_ba;
         rw_o <= !next_wr;
         rw_oe_o <= !next_ba;
         bus_avail_o <= next_ba;
         proc_state_code_o <= next_bs;
         final_cycle_marker_o <= (next_st == ST_RUN) && core_req_i && core_last_i && !core_sync_i;
         busy_o <= ((next_st == ST_RUN) && core_lock_i && !core_sync_i) ||
                   ((next_st == ST_RESET_VEC) && !int_rst && !vec_lo);
      end
   end

   // ---------------------------------------------------------------
   // Core handshake
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         core_step_o <= 1'b0;
         core_rdata_o <= 8'h0;
         core_reset_o <= 1'b1;
         next_cycle_use_o <= 1'b0;
      end else begin
         core_step_o <= cyc_end && !int_rst && ((st == ST_RESET_VEC) || (next_st == ST_RUN));
         if (e_fall && cur_acc && !cur_wr) core_rdata_o <= data_s;
         if (int_rst) core_reset_o <= 1'b1;
         else if (cyc_end && st == ST_RESET_VEC && vec_idx) core_reset_o <= 1'b0;
         next_cycle_use_o <= (st == ST_RUN) && !cur_sync && !core_sync_i && core_req_i;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt sampling and recognition
   // ---------------------------------------------------------------
   logic nmi_prev, quick_int_req_smp, irq_smp, nmi_latch, nmi_armed;
   logic nmi_rec, quick_int_req_rec, irq_rec, stealing, halted, quick_int_req_win;
   assign stealing = (st == ST_GRANT_DEAD) || (st == ST_GRANT);
   assign halted = (st == ST_HALT);
   assign quick_int_req_win = quick_int_req_rec && !core_fmask_i && !nmi_rec;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nmi_prev <= 1'b1;
         quick_int_req_smp <= 1'b1;
         irq_smp <= 1'b1;
         nmi_rec <= 1'b0;
         quick_int_req_rec <= 1'b0;
         irq_rec <= 1'b0;
      end else if (q_fall) begin
         nmi_prev <= nmi_s;
         if (!stealing) begin
            quick_int_req_smp <= quick_int_req_s;
            irq_smp <= irq_s;
         end
         nmi_rec <= nmi_latch;
         quick_int_req_rec <= !quick_int_req_smp;
         irq_rec <= !irq_smp;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nmi_armed <= 1'b0;
         nmi_latch <= 1'b0;
      end else if (int_rst) begin
         nmi_armed <= 1'b0;
         nmi_latch <= 1'b0;
      end else begin
         if (core_sp_loaded_i) nmi_armed <= 1'b1;
         if (q_fall && nmi_prev && !nmi_s && nmi_armed) nmi_latch <= 1'b1;
         else if (core_nmi_ack_i) nmi_latch <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         int_nmi_o <= 1'b0;
         int_quick_int_req_o <= 1'b0;
         int_irq_o <= 1'b0;
      end else begin
         int_nmi_o <= nmi_rec && !halted && !core_reset_o;
         int_quick_int_req_o <= quick_int_req_win && !halted && !core_reset_o;
         int_irq_o <= irq_rec && !core_imask_i && !quick_int_req_win && !nmi_rec && !halted && !core_reset_o;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_q_high_two: assert property ($rose(q_o) |=> q_o ##1 !q_o)
      else $error("quadrature high time not two quarters");
   a_q_leads_e: assert property ($rose(q_o) |=> $rose(e_o))
      else $error("enable did not follow quadrature");
   a_read_capture: assert property ($fell(e_o) && $past(cur_acc && !cur_wr) |-> core_rdata_o == $past(data_s))
      else $error("read data not captured at enable fall");
   a_write_valid: assert property ($rose(e_o) && cur_wr |-> data_oe_o && !rw_o && data_o == cur_wdata)
      else $error("write data not driven by enable rise");
   a_float_ba: assert property (bus_avail_o |-> !addr_oe_o && !data_oe_o && !rw_oe_o)
      else $error("bus driven while released");
   a_float_after: assert property ($fell(bus_avail_o) |-> !addr_oe_o [*4])
      else $error("address driven in dead cycle");
   a_dummy_ffff: assert property ($rose(q_o) && !cur_acc && addr_oe_o |-> addr_o == `BIF_DUMMY_ADDR && rw_o)
      else $error("idle cycle not a dummy read");
   a_halt_code: assert property (st == ST_HALT && $past(st == ST_HALT) |-> bus_avail_o && proc_state_code_o)
      else $error("halt state code wrong");
   a_vec_ack: assert property ($rose(q_o) && st == ST_RESET_VEC && cur_acc |-> !bus_avail_o && proc_state_code_o
                              && addr_o[15:1] == 15'h7fff)
      else $error("vector fetch without acknowledge");
   a_nmi_armed: assert property (int_nmi_o |-> nmi_armed)
      else $error("nmi recognised before stack load");
   a_int_prio: assert property (int_quick_int_req_o |-> !int_nmi_o && !int_irq_o)
      else $error("interrupt priority broken");
   a_irq_mask: assert property (int_irq_o |-> $past(!core_imask_i && !halted))
      else $error("masked normal request recognised");
   a_stretch_max: assert property (stretch_q <= `BIF_STRETCH_MAX_Q)
      else $error("stretch beyond ten cycles");
   a_grant_max: assert property (gcnt <= `BIF_GRANT_MAX - 4'h1)
      else $error("grant held too long");

   c_grant: cover property (st == ST_GRANT ##1 st == ST_RELEASE_DEAD);
   c_halt: cover property (st == ST_HALT);
   c_stretch: cover property (hold [*4]);
   c_nmi: cover property ($rose(int_nmi_o));

endmodule

// file: dv/bif_mem_model.sv
/*
 Memory and slow-device model on the far side of the bus controller.
 Assumes the controller's pins and the shared timing clock.
*/
`timescale 1ns/1ps
module bif_mem_model (
   input wire logic sys_clk_i,
   input wire logic e_i,
   input wire logic q_i,
   input wire bif_pkg::bif_addr_t addr_i,
   input wire logic addr_oe_i,
   input wire bif_pkg::bif_data_t data_i,
   input wire logic data_oe_i,
   input wire logic rw_i,
   input wire logic stretch_en_i,
   output bif_pkg::bif_data_t data_o,
   output logic ready_o
);
   import bif_pkg::*;
   bif_data_t mem [bif_addr_t];
   logic q_d = 1'b0;
   int hold = 0;
   bif_data_t junk = 8'h00;
   // ----
   // Read data, or a changing pattern when not read
   // ----
   initial data_o = 8'h00;
   always @(posedge sys_clk_i) junk <= ~junk;
   // Read data follows the address at once so it clears the pin synchroniser
   always @(addr_i or addr_oe_i or rw_i or junk) begin
      if (addr_oe_i && rw_i) begin
         data_o = mem.exists(addr_i) ? mem[addr_i] : (addr_i[7:0] ^ addr_i[15:8] ^ 8'h3c);
      end else begin
         data_o = junk;
      end
   end
   always @(negedge e_i) begin
      if (addr_oe_i && !rw_i && data_oe_i) begin
         mem[addr_i] = data_i;
      end
   end
   // Slow device asks to stretch every driven cycle, dummies too
   always @(posedge sys_clk_i) begin
      q_d <= q_i;
      if (q_i && !q_d && stretch_en_i && addr_oe_i) begin
         hold <= 12;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end
   end
   // Ready drops at quadrature rise already, then the counter holds it
   assign ready_o = (hold == 0) && !(q_i && !q_d && stretch_en_i && addr_oe_i);
endmodule

// file: dv/tb_top.sv
/*
 Self-checking bench for the bus interface controller; plays the core.
 Assumes bif_mem_model on the far side of the bus.
*/
`timescale 1ns/1ps
module tb_top;
   import bif_pkg::*;
   typedef struct {logic rd; bif_data_t val;} bif_note_t;
   logic sys_clk_i, sys_rst_i, reset_pin_n_i, halt_n_i, bus_request_in_n_i, slow_memory_stretch_i;
   logic nmi_n_i, quick_int_req_n_i, irq_n_i, stretch_en, pend_v;
   logic e_o, q_o, addr_oe_o, data_oe_o, rw_o, rw_oe_o, bus_avail_o, proc_state_code_o;
   logic final_cycle_marker_o, busy_o, next_cycle_use_o, core_step_o, core_reset_o;
   logic int_nmi_o, int_quick_int_req_o, int_irq_o, core_req_i, core_wr_i, core_last_i, core_lock_i;
   logic core_sp_loaded_i, core_nmi_ack_i, core_fmask_i, core_imask_i, core_vector_i, core_sync_i;
   bif_addr_t addr_o, core_addr_i;
   bif_data_t data_i, data_o, core_wdata_i, core_rdata_o;
   bif_data_t shadow [bif_addr_t];
   bif_note_t notes[$];
   bif_note_t pend;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 32'ha1e9553a;
   int i;
   logic [31:0] r;
   bif_bus_ctrl DUT (
      .sys_clk_i, .sys_rst_i, .reset_pin_n_i, .halt_n_i, .bus_request_in_n_i, .slow_memory_stretch_i,
      .nmi_n_i, .quick_int_req_n_i, .irq_n_i, .data_i, .e_o, .q_o, .addr_o, .addr_oe_o, .data_o,
      .data_oe_o, .rw_o, .rw_oe_o, .bus_avail_o, .proc_state_code_o, .final_cycle_marker_o, .busy_o,
      .next_cycle_use_o, .core_req_i, .core_addr_i, .core_wr_i, .core_wdata_i, .core_last_i,
      .core_lock_i, .core_vector_i, .core_sync_i, .core_sp_loaded_i, .core_nmi_ack_i,
      .core_fmask_i, .core_imask_i, .core_step_o, .core_rdata_o, .core_reset_o, .int_nmi_o,
      .int_quick_int_req_o, .int_irq_o
   );
   bif_mem_model u_mem (
      .sys_clk_i, .e_i(e_o), .q_i(q_o), .addr_i(addr_o), .addr_oe_i(addr_oe_o), .data_i(data_o),
      .data_oe_i(data_oe_o), .rw_i(rw_o), .stretch_en_i(stretch_en), .data_o(data_i),
      .ready_o(slow_memory_stretch_i)
   );
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // ----
   // Shared tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         #1;
      end
   endtask
   task automatic qrise();
      @(posedge q_o);
      #1;
   endtask
   task automatic qper(output int n);
      n = 0;
      while (q_o === 1'b1) begin
         tick(1);
         n++;
      end
      while (q_o !== 1'b1) begin
         tick(1);
         n++;
      end
   endtask
   task automatic idle(input int n);
      core_req_i = 1'b0;
      repeat (n) qrise();
   endtask
   // Hold the request until the step that takes it, then note the result
   task automatic do_op(input logic wr, input bif_addr_t a, input bif_data_t d, input logic last);
      bif_note_t nt;
      int n;
      {core_req_i, core_wr_i, core_addr_i, core_wdata_i, core_last_i} = {1'b1, wr, a, d, last};
      n = 0;
      do begin
         tick(1);
         n++;
      end while (core_step_o !== 1'b1 && n < 200);
      nt.rd = !wr;
      nt.val = shadow.exists(a) ? shadow[a] : (a[7:0] ^ a[15:8] ^ 8'h3c);
      if (wr) shadow[a] = d;
      notes.push_back(nt);
   endtask
   // Result of a cycle shows at the step after the one that took it
   always @(negedge sys_clk_i) begin
      if (core_step_o === 1'b1) begin
         if (pend_v && pend.rd) check(core_rdata_o, pend.val);
         pend_v = (notes.size() > 0);
         if (pend_v) pend = notes.pop_front();
      end
   end
   task automatic wait_int(input logic [2:0] want);
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
      end while ({int_nmi_o, int_quick_int_req_o, int_irq_o} !== want && n < 20);
      check({int_nmi_o, int_quick_int_req_o, int_irq_o}, want);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic vec_seq();
      int n;
      n = 0;
      do begin
         qrise();
         n++;
      end while (!(busy_o === 1'b1 && proc_state_code_o === 1'b1) && n < 12);
      check({addr_o, bus_avail_o, busy_o}, {16'hfffe, 2'b01});
      qrise();
      check({addr_o, bus_avail_o, proc_state_code_o}, {16'hffff, 2'b01});
      $display("test vector fetch done");
   endtask
   task automatic t_idle();
      int n;
      {core_req_i, stretch_en} = 2'b01;
      repeat (2) qrise();
      check({addr_o, rw_o, e_o}, {16'hffff, 2'b10});
      tick(1);
      check({q_o, e_o}, 2'b11);
      qper(n);
      check(n, 3);
      stretch_en = 1'b0;
      core_sync_i = 1'b1;
      qrise();
      check({bus_avail_o, proc_state_code_o, addr_oe_o, next_cycle_use_o}, 4'b1000);
      core_sync_i = 1'b0;
      qrise();
      check(addr_oe_o, 1'b0);
      $display("test idle cycles done");
   endtask
   task automatic t_rw();
      do_op(1'b1, 16'h4a05, 8'hc3, 1'b0);
      tick(1);
      check({rw_oe_o, rw_o, data_oe_o, addr_o, data_o}, {3'b101, 16'h4a05, 8'hc3});
      check(next_cycle_use_o, 1'b1);
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         core_lock_i = r[9];
         do_op(r[8], {12'h4a0, r[3:0]}, r[23:16], 1'b0);
      end
      core_lock_i = 1'b0;
      core_vector_i = 1'b1;
      do_op(1'b0, 16'hfffc, 8'h00, 1'b0);
      check({bus_avail_o, proc_state_code_o, addr_o}, {2'b01, 16'hfffc});
      core_vector_i = 1'b0;
      do_op(1'b0, 16'h4a05, 8'h00, 1'b0);
      idle(3);
      $display("test read write done");
   endtask
   task automatic t_stretch();
      int n;
      stretch_en = 1'b1;
      do_op(1'b0, 16'h4a03, 8'h00, 1'b0);
      core_req_i = 1'b0;
      n = 0;
      while (e_o !== 1'b1) tick(1);
      while (e_o === 1'b1) begin
         tick(1);
         n++;
      end
      check(n >= 8 && n <= 42, 1'b1);
      repeat (2) qrise();
      stretch_en = 1'b0;
      $display("test stretch done");
   endtask
   task automatic t_grant();
      int k;
      @(posedge e_o);
      #1;
      bus_request_in_n_i = 1'b0;
      k = 0;
      do begin
         qrise();
         k++;
      end while (bus_avail_o !== 1'b1 && k < 4);
      k = 0;
      while (bus_avail_o === 1'b1 && k < 40) begin
         check({proc_state_code_o, addr_oe_o, data_oe_o, rw_oe_o}, 4'b1000);
         k++;
         qrise();
      end
      bus_request_in_n_i = 1'b1;
      check(k >= 2 && k <= 15, 1'b1);
      check(addr_oe_o, 1'b0);
      qrise();
      check({addr_oe_o, addr_o}, {1'b1, 16'hffff});
      $display("test bus grant done");
   endtask
   task automatic t_ints();
      nmi_n_i = 1'b0;
      tick(20);
      check(int_nmi_o, 1'b0);
      {nmi_n_i, core_sp_loaded_i} = 2'b11;
      tick(1);
      core_sp_loaded_i = 1'b0;
      tick(5);
      {nmi_n_i, quick_int_req_n_i, irq_n_i, core_fmask_i, core_imask_i} = 5'h00;
      wait_int(3'b100);
      core_nmi_ack_i = 1'b1;
      tick(1);
      core_nmi_ack_i = 1'b0;
      wait_int(3'b010);
      quick_int_req_n_i = 1'b1;
      wait_int(3'b001);
      core_imask_i = 1'b1;
      wait_int(3'b000);
      {core_fmask_i, quick_int_req_n_i} = 2'b10;
      tick(20);
      check(int_quick_int_req_o, 1'b0);
      {nmi_n_i, quick_int_req_n_i, irq_n_i} = 3'b111;
      $display("test interrupts done");
   endtask
   task automatic t_halt();
      int n;
      do_op(1'b0, 16'h4a01, 8'h00, 1'b1);
      {core_req_i, core_last_i, halt_n_i} = 3'b000;
      tick(1);
      check(final_cycle_marker_o, 1'b1);
      n = 0;
      do begin
         qrise();
         n++;
      end while (bus_avail_o !== 1'b1 && n < 8);
      check({proc_state_code_o, addr_oe_o}, 2'b10);
      {quick_int_req_n_i, core_fmask_i} = 2'b00;
      repeat (4) qrise();
      qper(n);
      check(n, 4);
      check({int_quick_int_req_o, bus_avail_o}, 2'b01);
      {quick_int_req_n_i, core_fmask_i, halt_n_i} = 3'b111;
      idle(4);
      check(bus_avail_o, 1'b0);
      $display("test halt done");
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc > 6000) begin
         error_cnt++;
         $display("Error at %0t: run did not finish", $time);
         results();
      end
   end
   initial begin
      {sys_rst_i, reset_pin_n_i, halt_n_i, bus_request_in_n_i, nmi_n_i, quick_int_req_n_i} = 6'h3f;
      {irq_n_i, stretch_en, pend_v, core_req_i, core_wr_i, core_last_i} = 6'h20;
      {core_lock_i, core_sp_loaded_i, core_nmi_ack_i, core_fmask_i, core_imask_i, core_vector_i, core_sync_i} = 7'h0c;
      core_addr_i = 16'h0000;
      core_wdata_i = 8'h00;
      repeat (20) @(posedge sys_clk_i);
      #1;
      sys_rst_i = 1'b0;
      vec_seq();
      t_idle();
      t_rw();
      t_stretch();
      t_grant();
      t_ints();
      t_halt();
      reset_pin_n_i = 1'b0;
      tick(8);
      reset_pin_n_i = 1'b1;
      vec_seq();
      results();
   end
endmodule
